// [hw/module_rate_and_los_control.sv]
// rate select, loss of signal and transmit control with serial byte access
// Overview of operation
// R1 - high rate choice selects high-rate optimization
// R2 - low or open choice selects low-rate optimization
// R3 - byte 110: soft rate bit 3, state bit 4
// R4 - effective rate is soft bit OR pin
// R5 - signal-lost output low when input adequate
// R6 - loss detected from transition activity, fixed threshold
// R7 - signal-lost state mirrored at byte 110 bit 1
// R8 - unused transmit-off input is tied low by host
// R9 - soft transmit-off bit 6 ORed, state bit 7
// R10 - laser fault latches until transmit-off toggles
// R11 - undefined bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module module_rate_and_los_control
  import module_ctrl_pkg::*;
#(
  parameter int LOS_CYCLES = LOS_WINDOW_CYCLES // loss window in clocks
) (
  input wire logic clk, // 100 mhz system clock
  input wire logic rst, // async reset, active high
  input wire logic rateSelectPin, // host rate choice pin
  input wire logic txOffPin, // host transmit-off pin
  input wire logic laserFault, // laser fault indication from driver
  input wire logic rxDataLevel, // received data level from receiver
  input wire logic serialClock, // two-wire serial clock from host
  input wire logic serialDataIn, // two-wire serial data, wire level
  output logic serialDataOut, // serial data driven value, always low
  output logic serialDataOe, // high while pulling serial data low
  output logic rateHigh, // high-rate optimization selected
  output logic txShutdown, // transmitter shut down
  output logic txFault, // latched laser fault
  output logic receiveSignalLost // loss of received signal
);
  // two-flop synchronisers for every pin input
  logic [1:0] rateSync, txOffSync, faultSync, rxSync, sclSync, sdaSync;
  logic sclPrev, sdaPrev; // previous synchronised levels
  logic txOffPrev; // previous transmit-off pin level
  logic softRate; // writable soft rate bit
  logic softTxOff; // writable soft transmit-off bit
  logic losFlag; // loss flag from detector
  serial_state_type serState; // serial engine state
  logic [3:0] bitCount; // bits moved in current byte
  logic [7:0] shiftIn; // received bits
  logic [7:0] shiftOut; // bits being sent
  logic [1:0] byteIndex; // 0 device, 1 word address, 2 data
  logic readMode; // current transfer is a read
  logic [7:0] wordAddr; // current byte offset
  logic masterAck; // host acknowledged last read byte
  logic [7:0] readByte; // byte offered at the current offset

  // edge and condition decodes of the serial pins
  wire sclRise = sclSync[1] & ~sclPrev;
  wire sclFall = ~sclSync[1] & sclPrev;
  wire startCond = sclSync[1] & sclPrev & sdaPrev & ~sdaSync[1];
  wire stopCond = sclSync[1] & sclPrev & ~sdaPrev & sdaSync[1];
  wire pinTxOff = txOffSync[1]; // R8
  wire effRate = rateSync[1] | softRate; // R4
  wire effTxOff = pinTxOff | softTxOff; // R9

  // compose the readable control/status byte
  function automatic logic [7:0] statusByte(input logic [7:0] addr);
    logic [7:0] b;
    b = 8'h00; // R11
    if (addr == CTRL_STATUS_OFFSET) begin
      b[TX_OFF_STATE_BIT] = effTxOff; // R9
      b[SOFT_TX_OFF_BIT] = softTxOff; // R9
      b[RATE_STATE_BIT] = effRate; // R3
      b[SOFT_RATE_BIT] = softRate; // R3
      b[TX_FAULT_BIT] = txFault; // R10
      b[RX_LOST_BIT] = receiveSignalLost; // R7
    end
    return b;
  endfunction : statusByte

  // byte that the next read slot will send; follows live status
  always_comb begin
    readByte = statusByte(wordAddr);
  end

  // synchronise all pin inputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rateSync <= 2'h0;
      txOffSync <= 2'h3;
      faultSync <= 2'h0;
      rxSync <= 2'h0;
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
    end else begin
      rateSync <= {rateSync[0], rateSelectPin};
      txOffSync <= {txOffSync[0], txOffPin};
      faultSync <= {faultSync[0], laserFault};
      rxSync <= {rxSync[0], rxDataLevel};
      sclSync <= {sclSync[0], serialClock};
      sdaSync <= {sdaSync[0], serialDataIn};
    end
  end

  // previous levels for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      txOffPrev <= 1'b1;
    end else begin
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
      txOffPrev <= pinTxOff;
    end
  end

  // loss-of-signal detector
  los_detector #(
    .WINDOW_CYCLES(LOS_CYCLES)
  ) u_los (
    .clk(clk),
    .rst(rst),
    .dataLevel(rxSync[1]),
    .signalLost(losFlag)
  );

  // registered pin outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rateHigh <= 1'b0;
      txShutdown <= 1'b1;
      receiveSignalLost <= 1'b1;
      serialDataOut <= 1'b0;
    end else begin
      rateHigh <= effRate; // R1 R2 R4
      txShutdown <= effTxOff | txFault; // R9 R10
      receiveSignalLost <= losFlag; // R5
      serialDataOut <= 1'b0;
    end
  end

  // laser fault latch: set wins over the toggle clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txFault <= 1'b0;
    end else if (faultSync[1]) begin
      txFault <= 1'b1; // R10
    end else if (pinTxOff != txOffPrev) begin
      txFault <= 1'b0; // R10
    end
  end

  // soft bits written by a serial data byte at the control offset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      softRate <= SOFT_RATE_RESET;
      softTxOff <= SOFT_TX_OFF_RESET;
    end else if (serState == SER_RX_BYTE && sclFall && bitCount == 4'h8
                 && byteIndex == 2'h2 && wordAddr == CTRL_STATUS_OFFSET) begin
      softRate <= shiftIn[SOFT_RATE_BIT]; // R3
      softTxOff <= shiftIn[SOFT_TX_OFF_BIT]; // R9
    end
  end

  // serial engine: device address, word address, data bytes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serState <= SER_IDLE;
      bitCount <= 4'h0;
      shiftIn <= 8'h00;
      shiftOut <= 8'h00;
      byteIndex <= 2'h0;
      readMode <= 1'b0;
      wordAddr <= 8'h00;
      masterAck <= 1'b0;
      serialDataOe <= 1'b0;
    end else if (stopCond) begin
      serState <= SER_IDLE; // stop ends any transfer
      serialDataOe <= 1'b0;
    end else if (startCond) begin
      serState <= SER_RX_BYTE; // start or repeated start
      bitCount <= 4'h0;
      byteIndex <= 2'h0;
      serialDataOe <= 1'b0;
    end else begin
      case (serState)
        SER_IDLE: begin
          serialDataOe <= 1'b0;
        end
        SER_RX_BYTE: begin
          if (sclRise && bitCount != 4'h8) begin
            shiftIn <= {shiftIn[6:0], sdaSync[1]};
            bitCount <= bitCount + 4'h1;
          end else if (sclFall && bitCount == 4'h8) begin
            serState <= SER_SEND_ACK;
            serialDataOe <= 1'b1; // acknowledge by default
            if (byteIndex == 2'h0) begin
              if (shiftIn[7:1] == DIAG_DEV_ADDR) begin
                readMode <= shiftIn[0];
                byteIndex <= 2'h1;
              end else begin
                serState <= SER_IDLE; // not our address
                serialDataOe <= 1'b0;
              end
            end else if (byteIndex == 2'h1) begin
              wordAddr <= shiftIn; // set byte offset
              byteIndex <= 2'h2;
            end else begin
              wordAddr <= wordAddr + 8'h01; // advance after write
            end
          end
        end
        SER_SEND_ACK: begin
          if (sclFall) begin
            bitCount <= 4'h0;
            if (readMode) begin
              serState <= SER_TX_BYTE;
              shiftOut <= readByte; // R7
              serialDataOe <= ~readByte[7];
              wordAddr <= wordAddr + 8'h01;
            end else begin
              serState <= SER_RX_BYTE;
              serialDataOe <= 1'b0;
            end
          end
        end
        SER_TX_BYTE: begin
          if (sclRise) begin
            bitCount <= bitCount + 4'h1;
          end else if (sclFall) begin
            if (bitCount == 4'h8) begin
              serState <= SER_GET_ACK; // release for host ack
              serialDataOe <= 1'b0;
            end else begin
              shiftOut <= {shiftOut[6:0], 1'b0};
              serialDataOe <= ~shiftOut[6];
            end
          end
        end
        SER_GET_ACK: begin
          if (sclRise) begin
            masterAck <= ~sdaSync[1];
          end else if (sclFall) begin
            if (masterAck) begin
              serState <= SER_TX_BYTE;
              bitCount <= 4'h0;
              shiftOut <= readByte; // R7
              serialDataOe <= ~readByte[7];
              wordAddr <= wordAddr + 8'h01;
            end else begin
              serState <= SER_IDLE; // host ended the read
              serialDataOe <= 1'b0;
            end
          end
        end
        default: begin
          serState <= SER_IDLE;
          serialDataOe <= 1'b0;
        end
      endcase
    end
  end
endmodule : module_rate_and_los_control
`default_nettype wire

// [hw/module_ctrl_pkg.sv]
// shared constants for the module rate, loss-of-signal and control byte
package module_ctrl_pkg;
  // serial device address 0xa2 as a 7-bit address
  localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;
  // control/status byte offset on that device
  localparam logic [7:0] CTRL_STATUS_OFFSET = 8'h6e;
  // bit positions inside the control/status byte
  localparam int TX_OFF_STATE_BIT = 7;
  localparam int SOFT_TX_OFF_BIT = 6;
  localparam int RATE_STATE_BIT = 4;
  localparam int SOFT_RATE_BIT = 3;
  localparam int TX_FAULT_BIT = 2;
  localparam int RX_LOST_BIT = 1;
  // reset values of the writable soft bits
  localparam logic SOFT_TX_OFF_RESET = 1'b0;
  localparam logic SOFT_RATE_RESET = 1'b0;
  // clock period and the silence window that declares loss of signal
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOS_WINDOW_NS = 2000;
  localparam int LOS_WINDOW_CYCLES = LOS_WINDOW_NS / CLK_PERIOD_NS;
  // serial engine states
  typedef enum logic [2:0] {
    SER_IDLE, SER_RX_BYTE, SER_SEND_ACK, SER_TX_BYTE, SER_GET_ACK
  } serial_state_type;
endpackage : module_ctrl_pkg

// [hw/los_detector.sv]
// transition-activity detector that flags loss of received signal
`timescale 1ns/1ps
`default_nettype none
module los_detector
  import module_ctrl_pkg::*;
#(
  parameter int WINDOW_CYCLES = LOS_WINDOW_CYCLES // silence before loss
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic dataLevel, // synchronised receive data level
  output logic signalLost // high after a full window without transitions
);
  localparam int CW = $clog2(WINDOW_CYCLES + 1);
  localparam logic [CW-1:0] WINDOW_LAST = CW'(WINDOW_CYCLES - 1);

  logic prevLevel; // last sampled level
  logic [CW-1:0] quietCount; // cycles since last transition

  // remember previous level for edge finding
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prevLevel <= 1'b0;
    end else begin
      prevLevel <= dataLevel;
    end
  end

  // count quiet cycles; any transition restarts the window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quietCount <= '0;
    end else if (dataLevel != prevLevel) begin // R6
      quietCount <= '0;
    end else if (quietCount != WINDOW_LAST) begin
      quietCount <= quietCount + 1'b1;
    end
  end

  // fixed threshold: loss only after a full silent window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      signalLost <= 1'b1;
    end else if (dataLevel != prevLevel) begin
      signalLost <= 1'b0; // R5
    end else if (quietCount == WINDOW_LAST) begin
      signalLost <= 1'b1; // R5 R6
    end
  end
endmodule : los_detector
`default_nettype wire

// [verif/rate_loss_monitor.sv]
// port checker for rate, signal-lost, fault and serial line behaviour
`timescale 1ns/1ps
`default_nettype none
module rate_loss_monitor #(
  parameter int LOS_CYCLES = 200 // loss window in clocks
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset
  input wire logic rateSelectPin, // rate pin
  input wire logic txOffPin, // tx-off pin
  input wire logic laserFault, // fault input
  input wire logic rxDataLevel, // received data
  input wire logic serialClock, // serial clock
  input wire logic serialDataOut, // serial data value
  input wire logic serialDataOe, // serial data enable
  input wire logic rateHigh, // rate output
  input wire logic txShutdown, // shutdown output
  input wire logic txFault, // fault output
  input wire logic receiveSignalLost // signal-lost output
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] quiet; // clocks since last rx transition
  logic [3:0] sinceTog; // clocks since tx-off pin change
  logic seenEdge; // any rx transition seen
  // activity counters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quiet <= '0;
      sinceTog <= 4'hf;
      seenEdge <= 1'b0;
    end else begin
      quiet <= $changed(rxDataLevel) ? '0 : quiet + {15'h0, &quiet == 0};
      sinceTog <= $changed(txOffPin) ? '0
        : sinceTog + {3'h0, sinceTog != 4'hf};
      seenEdge <= seenEdge | $changed(rxDataLevel);
    end
  end
  // a level held over the whole pin pipeline
  sequence held4(s);
    s [*4];
  endsequence
  // fault flag first, laser shut down one clock later
  sequence fault_then_off;
    txFault ##1 (txFault && txShutdown);
  endsequence
  a_rate_by_pin: assert property (held4(rateSelectPin) |-> rateHigh)
    else $error("rate pin ignored");
  a_tx_by_pin: assert property (held4(txOffPin) |-> txShutdown)
    else $error("tx-off pin ignored");
  a_fault_latch: assert property (held4(laserFault) |-> fault_then_off)
    else $error("fault not latched");
  a_fault_clear: assert property ($fell(txFault) |-> sinceTog < 4'h6)
    else $error("fault cleared without toggle");
  a_loss_clear: assert property ($changed(rxDataLevel)
    |-> ##[1:6] !receiveSignalLost)
    else $error("signal-lost stuck high");
  a_loss_set: assert property (quiet == LOS_CYCLES + 8 |-> receiveSignalLost)
    else $error("signal-lost not raised");
  a_loss_hold: assert property (seenEdge && quiet > 6
    && quiet < LOS_CYCLES - 1 |-> !receiveSignalLost)
    else $error("signal-lost raised early");
  a_sda_change: assert property ($changed(serialDataOe) |-> !serialClock)
    else $error("data moved while clock high");
  a_sda_pull: assert property (serialDataOe |-> !serialDataOut)
    else $error("data driven high");
endmodule : rate_loss_monitor
bind module_rate_and_los_control rate_loss_monitor #(.LOS_CYCLES(LOS_CYCLES))
  i_rate_loss_monitor (.clk, .rst, .rateSelectPin, .txOffPin, .laserFault,
  .rxDataLevel, .serialClock, .serialDataOut, .serialDataOe, .rateHigh,
  .txShutdown, .txFault, .receiveSignalLost);
`default_nettype wire

// [verif/host_serial_model.sv]
// two-wire host controller model driving serial clock and data
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
  input wire logic sdaWire, // resolved data line
  output logic serialClock, // serial clock, idles high
  output logic hostPullLow // high while host pulls data low
);
  realtime qt = 31.25ns; // quarter bit time, 125 ns per bit; the bench raises it for a slow host
  // idle: both lines released
  initial begin
    serialClock = 1'b1;
    hostPullLow = 1'b0;
  end
  // start or repeated start: data falls while clock high
  task automatic start();
    hostPullLow = 1'b0;
    #qt serialClock = 1'b1;
    #qt hostPullLow = 1'b1;
    #qt serialClock = 1'b0;
    #qt;
  endtask : start
  // stop: data rises while clock high, clock then stands high
  task automatic stop();
    hostPullLow = 1'b1;
    #qt serialClock = 1'b1;
    #qt hostPullLow = 1'b0;
    #qt;
  endtask : stop
  // eight bits msb first plus answer slot; a 1 releases the line
  task automatic xbyte(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      hostPullLow = !d[i];
      #qt serialClock = 1'b1;
      #qt r[i] = sdaWire;
      #qt serialClock = 1'b0;
      #qt;
    end
  endtask : xbyte
endmodule : host_serial_model
`default_nettype wire

// [verif/module_rate_and_los_control_tb.sv]
// bench: byte access, rate choice, signal-lost and fault behaviour
`timescale 1ns/1ps
`default_nettype none
module module_rate_and_los_control_tb import module_ctrl_pkg::*; ();
  localparam int WIN = 16; // short loss window
  localparam logic [7:0] OFF = CTRL_STATUS_OFFSET; // control byte
  logic clk, rst, rateSelectPin, txOffPin, laserFault, rxDataLevel;
  logic toggling; // keeps rx data moving
  logic [8:0] r; // last byte heard
  wire serialClock, hostPullLow, sdaOut, sdaOe;
  wire rateHigh, txShutdown, txFault, receiveSignalLost;
  wire sdaWire = !(hostPullLow || (sdaOe && !sdaOut)); // pulled-up line
  wire [7:0] outs = {4'h0, rateHigh, txShutdown, txFault, receiveSignalLost};
  int errors = 0; // mismatches
  int num_checks = 0; // comparisons
  module_rate_and_los_control #(
    .LOS_CYCLES(WIN)
  ) i_module_rate_and_los_control (
    .clk, .rst, .rateSelectPin, .txOffPin, .laserFault, .rxDataLevel,
    .serialClock, .serialDataIn(sdaWire), .serialDataOut(sdaOut),
    .serialDataOe(sdaOe), .rateHigh, .txShutdown, .txFault, .receiveSignalLost);
  host_serial_model i_host_serial_model (.sdaWire, .serialClock, .hostPullLow);
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // rx activity source
  always @(negedge clk) if (toggling) rxDataLevel <= !rxDataLevel;
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // write one byte, all three slots acknowledged
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    logic [8:0] a, b, c;
    i_host_serial_model.start();
    i_host_serial_model.xbyte({DIAG_DEV_ADDR, 2'b01}, a);
    i_host_serial_model.xbyte({off, 1'b1}, b);
    i_host_serial_model.xbyte({d, 1'b1}, c);
    i_host_serial_model.stop();
    check({5'h0, a[0], b[0], c[0]}, 8'h00);
    cyc(1);
  endtask : wr
  // random read, host refuses after the data byte
  task automatic rd(input logic [7:0] off, input logic [7:0] exp);
    logic [8:0] a, b, c, e;
    i_host_serial_model.start();
    i_host_serial_model.xbyte({DIAG_DEV_ADDR, 2'b01}, a);
    i_host_serial_model.xbyte({off, 1'b1}, b);
    i_host_serial_model.start();
    i_host_serial_model.xbyte({DIAG_DEV_ADDR, 2'b11}, c);
    i_host_serial_model.xbyte(9'h1ff, e);
    i_host_serial_model.stop();
    check({5'h0, a[0], b[0], c[0]}, 8'h00);
    check(e[8:1], exp);
    cyc(1);
  endtask : rd
  // watchdog
  initial begin
    #400us;
    errors++;
    report_and_stop();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    rateSelectPin = 1'b0;
    txOffPin = 1'b0;
    laserFault = 1'b0;
    rxDataLevel = 1'b0;
    toggling = 1'b0;
    cyc(6);
    rst = 1'b0;
    cyc(4);
    check(outs, 8'h01);
    rd(OFF, 8'h02);
    $display("test reset done");
    rateSelectPin = 1'b1;
    cyc(5);
    check(outs, 8'h09);
    rd(OFF, 8'h12);
    rateSelectPin = 1'b0;
    cyc(5);
    check(outs, 8'h01);
    wr(OFF, 8'hff);
    cyc(3);
    check(outs, 8'h0d);
    rd(OFF, 8'hda);
    wr(OFF, 8'h00);
    rd(OFF, 8'h02);
    $display("test soft bits done");
    toggling = 1'b1;
    cyc(10);
    check(outs, 8'h00);
    rd(OFF, 8'h00);
    toggling = 1'b0;
    cyc(WIN + 10);
    check(outs, 8'h01);
    rd(OFF, 8'h02);
    $display("test signal lost done");
    laserFault = 1'b1;
    cyc(5);
    laserFault = 1'b0;
    cyc(5);
    check(outs, 8'h07);
    rd(OFF, 8'h06);
    txOffPin = 1'b1;
    cyc(5);
    check(outs, 8'h05);
    rd(OFF, 8'h82);
    txOffPin = 1'b0;
    cyc(5);
    check(outs, 8'h01);
    $display("test fault done");
    i_host_serial_model.qt = 100ns;
    wr(8'h10, 8'h55);
    rd(8'h10, 8'h00);
    i_host_serial_model.qt = 31.25ns;
    i_host_serial_model.start();
    i_host_serial_model.xbyte(9'h141, r);
    i_host_serial_model.stop();
    check({7'h0, r[0]}, 8'h01);
    // two-byte read from the offset below: host acks the first byte
    i_host_serial_model.start();
    i_host_serial_model.xbyte({DIAG_DEV_ADDR, 2'b01}, r);
    i_host_serial_model.xbyte({OFF - 8'h01, 1'b1}, r);
    i_host_serial_model.start();
    i_host_serial_model.xbyte({DIAG_DEV_ADDR, 2'b11}, r);
    i_host_serial_model.xbyte(9'h1fe, r);
    check(r[8:1], 8'h00);
    i_host_serial_model.xbyte(9'h1ff, r);
    check(r[8:1], 8'h02);
    i_host_serial_model.stop();
    cyc(1);
    rd(OFF, 8'h02);
    $display("test serial edges done");
    report_and_stop();
  end
endmodule : module_rate_and_los_control_tb
`default_nettype wire
